// ### colm_consts.svh
// Constants of the operation-level monitor: offsets, field positions, limits, timing
`ifndef COLM_CONSTS_SVH
`define COLM_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define COLM_A_CFG 8'h00
`define COLM_A_SP 8'h04
`define COLM_A_MSP0 8'h08
`define COLM_A_MSP1 8'h0c
`define COLM_A_MSP2 8'h10
`define COLM_A_MSP3 8'h14
`define COLM_A_RAMP 8'h18
`define COLM_A_HBTH 8'h1c
`define COLM_A_OCTH 8'h20
`define COLM_A_HSTH 8'h24
`define COLM_A_SOAK 8'h28
`define COLM_A_RUN 8'h2c
`define COLM_A_PROG 8'h30
`define COLM_A_MSEL 8'h34
`define COLM_A_AUTO 8'h38
`define COLM_A_AL1 8'h3c
`define COLM_A_STAT 8'h40
`define COLM_A_CTMON 8'h44
`define COLM_A_LKMON 8'h48
`define COLM_A_RSMON 8'h4c

// ****************************************
// Fields and values
// ****************************************
`define COLM_CFG_W 22
`define COLM_EV_NONE 3'h0
`define COLM_EV_MSP 3'h1
`define COLM_EV_RUN 3'h2
`define COLM_EV_AM 3'h3
`define COLM_EV_PROG 3'h4
`define COLM_CUR_MAX 16'h0226
`define COLM_CUR_OVF 16'hffff
`define COLM_AL_MIN 16'hf831
`define COLM_AL_MAX 16'h270f
`define COLM_SEC_MIN 12'h03c
`define COLM_SEC_HOUR 12'he10

// ****************************************
// Timing
// ****************************************
`define COLM_CLK_HZ 125000000
`define COLM_KEY_HOLD_MS 3000
`define COLM_GATE_MS 100
`define COLM_SEC_MS 1000
`define COLM_KEY_HOLD_CYC (`COLM_KEY_HOLD_MS * (`COLM_CLK_HZ / 1000))
`define COLM_GATE_CYC (`COLM_GATE_MS * (`COLM_CLK_HZ / 1000))
`define COLM_SEC_CYC (`COLM_SEC_MS * (`COLM_CLK_HZ / 1000))

`endif

// ### colm_pkg.sv
// Types of the operation-level monitor
package colm_pkg;

  // Configuration word, written as one register
  typedef struct packed {
    logic [4:0] al1_type;
    logic [2:0] ev2_fn;
    logic [2:0] ev1_fn;
    logic soak_hours;
    logic prog_pat;
    logic self_tuning;
    logic two_ct;
    logic hs_use;
    logic oc_use;
    logic hb_use;
    logic al1_asg;
    logic msp_en;
    logic am_add;
    logic two_dof;
  } colm_cfg_s;

  // Alarm state of one current channel
  typedef struct packed {
    logic hb;
    logic oc;
    logic hs;
  } colm_ch_s;

  typedef enum logic [1:0] {KEY_IDLE, KEY_HOLD, KEY_DONE} colm_key_e;

endpackage : colm_pkg

// ### colm_top.sv
// Operation-level control and monitoring logic of a temperature controller
//
// Decided for this implementation: the address map and the plain strobed port.
`include "colm_consts.svh"

module colm_top import colm_pkg::*; #(
  parameter int unsigned KEY_HOLD_CYC = `COLM_KEY_HOLD_CYC,
  parameter int unsigned GATE_CYC = `COLM_GATE_CYC,
  parameter int unsigned SEC_CYC = `COLM_SEC_CYC
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic MODE_KEY_I,
  input wire logic [1:0] EVENT_IN_I,
  input wire logic AM_ITEM_SHOWN_I,
  input wire logic HEAT_OUT_I,
  input wire logic [15:0] CT_HEAT1_I,
  input wire logic [15:0] CT_HEAT2_I,
  input wire logic [15:0] CT_LEAK1_I,
  input wire logic [15:0] CT_LEAK2_I,
  output logic MANUAL_O,
  output logic MANUAL_LEVEL_O,
  output logic RUN_O,
  output logic STOP_LAMP_O,
  output logic PROG_RUN_O,
  output logic HEATER_ALARM_LAMP_O,
  output logic [3:0] FLASH_O,
  output logic [15:0] RAMP_SP_O
);

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  logic rst_s1, rst_n;
  logic key_s1, key_s2;
  logic [1:0] ev_s1, ev_s2, ev_prev;

  // Reset is asserted at once and released after two edges
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Key and event pins are asynchronous to the clock
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      key_s1 <= 1'b0;
      key_s2 <= 1'b0;
      ev_s1 <= 2'h0;
      ev_s2 <= 2'h0;
      ev_prev <= 2'h0;
    end else begin
      key_s1 <= MODE_KEY_I;
      key_s2 <= key_s1;
      ev_s1 <= EVENT_IN_I;
      ev_s2 <= ev_s1;
      ev_prev <= ev_s2;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  colm_cfg_s cfg_r;
  logic signed [15:0] sp_r, al1_r;
  logic signed [15:0] msp_r [4];
  logic [15:0] ramp_rate_r, hb_th_r, oc_th_r, hs_th_r, soak_r;
  logic [1:0] msel_r;
  // Visibility of the alarm 1 value gates its writes, so it is declared ahead of them
  logic al1_vis;

  // Plain settings; alarm 1 value is clamped into its range
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= '0;
      sp_r <= 16'h0000;
      msp_r <= '{default: 16'h0000};
      ramp_rate_r <= 16'h0000;
      hb_th_r <= 16'h0000;
      oc_th_r <= 16'h0000;
      hs_th_r <= 16'h0000;
      soak_r <= 16'h0000;
      msel_r <= 2'h0;
      al1_r <= 16'h0000;
    end else if (WR_I) begin
      unique case (ADDR_I)
        `COLM_A_CFG: cfg_r <= colm_cfg_s'(WDATA_I[`COLM_CFG_W-1:0]);
        `COLM_A_SP: sp_r <= WDATA_I[15:0];
        `COLM_A_MSP0: msp_r[0] <= WDATA_I[15:0];
        `COLM_A_MSP1: msp_r[1] <= WDATA_I[15:0];
        `COLM_A_MSP2: msp_r[2] <= WDATA_I[15:0];
        `COLM_A_MSP3: msp_r[3] <= WDATA_I[15:0];
        `COLM_A_RAMP: ramp_rate_r <= WDATA_I[15:0];
        `COLM_A_HBTH: hb_th_r <= WDATA_I[15:0];
        `COLM_A_OCTH: oc_th_r <= WDATA_I[15:0];
        `COLM_A_HSTH: hs_th_r <= WDATA_I[15:0];
        `COLM_A_SOAK: soak_r <= WDATA_I[15:0];
        `COLM_A_MSEL: msel_r <= WDATA_I[1:0];
        `COLM_A_AL1: begin
          if (al1_vis) begin
            if ($signed(WDATA_I[15:0]) < $signed(`COLM_AL_MIN))
              al1_r <= `COLM_AL_MIN;
            else if ($signed(WDATA_I[15:0]) > $signed(`COLM_AL_MAX))
              al1_r <= `COLM_AL_MAX;
            else
              al1_r <= WDATA_I[15:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // Item visibility and event assignment
  // ****************************************
  logic [1:0] ev_am, ev_run, ev_prog, ev_msp;
  logic am_offered, ramp_vis, ct1_vis, ct2_vis, lk1_vis, lk2_vis, prog_vis, run_vis;
  assign ev_am = {cfg_r.ev2_fn == `COLM_EV_AM, cfg_r.ev1_fn == `COLM_EV_AM};
  assign ev_run = {cfg_r.ev2_fn == `COLM_EV_RUN, cfg_r.ev1_fn == `COLM_EV_RUN};
  assign ev_prog = {cfg_r.ev2_fn == `COLM_EV_PROG, cfg_r.ev1_fn == `COLM_EV_PROG};
  assign ev_msp = {cfg_r.ev2_fn == `COLM_EV_MSP, cfg_r.ev1_fn == `COLM_EV_MSP};
  assign am_offered = cfg_r.two_dof && cfg_r.am_add && (ev_am == 2'h0);
  assign ramp_vis = (ramp_rate_r != 16'h0000) && !cfg_r.self_tuning;
  assign ct1_vis = cfg_r.al1_asg && (cfg_r.hb_use || cfg_r.oc_use);
  assign ct2_vis = ct1_vis && cfg_r.two_ct;
  assign lk1_vis = cfg_r.al1_asg && cfg_r.hs_use;
  assign lk2_vis = lk1_vis && cfg_r.two_ct;
  assign prog_vis = cfg_r.prog_pat;
  assign run_vis = (ev_run == 2'h0);
  assign al1_vis = cfg_r.al1_asg && !(cfg_r.al1_type inside {5'h00, 5'h01, 5'h04, 5'h05, 5'h0c});

  // ****************************************
  // Time base: one-second enable
  // ****************************************
  logic [31:0] sec_cnt;
  logic sec_tick, blink_r;
  assign sec_tick = (sec_cnt == SEC_CYC - 1);

  // Blink phase toggles each second for the flashing displays
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt <= 32'h0;
      blink_r <= 1'b0;
    end else begin
      sec_cnt <= sec_tick ? 32'h0 : sec_cnt + 32'h1;
      if (sec_tick)
        blink_r <= ~blink_r;
    end
  end

  // ****************************************
  // Mode key hold and auto/manual
  // ****************************************
  colm_key_e key_st;
  logic [31:0] key_cnt;
  logic key_fire, manual_r, man_lvl_r;
  assign key_fire = (key_st == KEY_HOLD) && key_s2 && AM_ITEM_SHOWN_I && am_offered
                    && (key_cnt >= KEY_HOLD_CYC - 1);

  // Releasing the key or leaving the item drops the count, so short presses do nothing
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      key_st <= KEY_IDLE;
      key_cnt <= 32'h0;
    end else if (!key_s2 || !AM_ITEM_SHOWN_I || !am_offered) begin
      key_st <= KEY_IDLE;
      key_cnt <= 32'h0;
    end else begin
      unique case (key_st)
        KEY_IDLE: begin
          key_st <= KEY_HOLD;
          key_cnt <= 32'h1;
        end
        KEY_HOLD: begin
          if (key_fire)
            key_st <= KEY_DONE;
          else
            key_cnt <= key_cnt + 32'h1;
        end
        KEY_DONE: ;
      endcase
    end
  end

  // Manual wins over a simultaneous return-to-auto write
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      manual_r <= 1'b0;
      man_lvl_r <= 1'b0;
    end else begin
      man_lvl_r <= key_fire;
      if (ev_am != 2'h0)
        manual_r <= |(ev_s2 & ev_am);
      else if (key_fire)
        manual_r <= 1'b1;
      else if (WR_I && (ADDR_I == `COLM_A_AUTO) && WDATA_I[0])
        manual_r <= 1'b0;
    end
  end

  // ****************************************
  // Set point selection and ramp
  // ****************************************
  logic [1:0] act_idx_r;
  logic signed [15:0] target, ramp_r;
  logic signed [16:0] diff;
  assign target = cfg_r.msp_en ? msp_r[act_idx_r] : sp_r;
  assign diff = 17'(target) - 17'(ramp_r);

  // Events that carry a select bit override the key selection
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n)
      act_idx_r <= 2'h0;
    else if (ev_msp != 2'h0)
      act_idx_r <= ev_s2 & ev_msp;
    else
      act_idx_r <= msel_r;
  end

  // Ramp steps once a second by at most the rate; rate zero follows the target
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n)
      ramp_r <= 16'h0000;
    else if (ramp_rate_r == 16'h0000)
      ramp_r <= target;
    else if (sec_tick) begin
      if (diff > $signed({1'b0, ramp_rate_r}))
        ramp_r <= 16'(ramp_r + ramp_rate_r);
      else if (diff < -$signed({1'b0, ramp_rate_r}))
        ramp_r <= 16'(ramp_r - ramp_rate_r);
      else
        ramp_r <= target;
    end
  end

  // ****************************************
  // Run/stop and simple program
  // ****************************************
  logic prog_start, prog_stop, prog_run_r, run_r, unit_tick;
  logic [15:0] soak_rem_r;
  logic [11:0] unit_cnt;
  assign prog_start = prog_vis && ((ev_prog != 2'h0) ? |(ev_s2 & ~ev_prev & ev_prog)
                      : (WR_I && (ADDR_I == `COLM_A_PROG) && WDATA_I[0]));
  assign prog_stop = (ev_prog != 2'h0) ? |(~ev_s2 & ev_prev & ev_prog)
                     : (WR_I && (ADDR_I == `COLM_A_PROG) && !WDATA_I[0]);
  assign unit_tick = sec_tick && (unit_cnt == (cfg_r.soak_hours ? `COLM_SEC_HOUR : `COLM_SEC_MIN) - 12'h1);

  // Event assignment overrides the item; program start forces run otherwise
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n)
      run_r <= 1'b1;
    else if (ev_run != 2'h0)
      run_r <= ~|(ev_s2 & ev_run);
    else if (prog_start)
      run_r <= 1'b1;
    else if (WR_I && (ADDR_I == `COLM_A_RUN))
      run_r <= WDATA_I[0];
  end

  // Soak counts down in whole units; reaching zero ends the program
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      prog_run_r <= 1'b0;
      soak_rem_r <= 16'h0000;
      unit_cnt <= 12'h000;
    end else if (prog_start) begin
      prog_run_r <= 1'b1;
      soak_rem_r <= soak_r;
      unit_cnt <= 12'h000;
    end else if (prog_stop || !prog_vis) begin
      prog_run_r <= 1'b0;
    end else if (prog_run_r) begin
      if (soak_rem_r == 16'h0000)
        prog_run_r <= 1'b0;
      else if (sec_tick) begin
        unit_cnt <= unit_tick ? 12'h000 : unit_cnt + 12'h001;
        if (unit_tick)
          soak_rem_r <= soak_rem_r - 16'h0001;
      end
    end
  end

  // ****************************************
  // Heater current monitors and alarms
  // ****************************************
  logic [31:0] on_cnt, off_cnt;
  logic on_long, off_long;
  colm_ch_s ch_r [2];
  logic [15:0] heat [2];
  logic [15:0] leak [2];
  logic [15:0] mon_r [4];
  logic [1:0] ch_on;
  assign on_long = HEAT_OUT_I && (on_cnt >= GATE_CYC);
  assign off_long = !HEAT_OUT_I && (off_cnt >= GATE_CYC);
  assign heat = '{CT_HEAT1_I, CT_HEAT2_I};
  assign leak = '{CT_LEAK1_I, CT_LEAK2_I};
  assign ch_on = {cfg_r.two_ct, 1'b1};

  // Length of the present on- or off-period, saturating
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      on_cnt <= 32'h0;
      off_cnt <= 32'h0;
    end else begin
      on_cnt <= !HEAT_OUT_I ? 32'h0 : (on_long ? on_cnt : on_cnt + 32'h1);
      off_cnt <= HEAT_OUT_I ? 32'h0 : (off_long ? off_cnt : off_cnt + 32'h1);
    end
  end

  // Alarms are judged only in long periods and hold across short ones
  for (genvar c = 0; c < 2; c++) begin : g_ch
    always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
        ch_r[c] <= '0;
      end else begin
        if (on_long) begin
          ch_r[c].hb <= ch_on[c] && cfg_r.al1_asg && cfg_r.hb_use && (heat[c] < hb_th_r);
          ch_r[c].oc <= ch_on[c] && cfg_r.al1_asg && cfg_r.oc_use && (heat[c] > oc_th_r);
        end
        if (off_long)
          ch_r[c].hs <= ch_on[c] && lk1_vis && (leak[c] > hs_th_r);
      end
    end
    // Over-range readings show the overflow pattern
    always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
        mon_r[c] <= 16'h0000;
        mon_r[c+2] <= 16'h0000;
      end else begin
        mon_r[c] <= (heat[c] > `COLM_CUR_MAX) ? `COLM_CUR_OVF : heat[c];
        mon_r[c+2] <= (leak[c] > `COLM_CUR_MAX) ? `COLM_CUR_OVF : leak[c];
      end
    end
  end

  // ****************************************
  // Outputs and read port
  // ****************************************
  logic lamp_r, stop_lamp_r;
  logic [3:0] flash_r;
  logic [31:0] rdata_r, status;
  assign status = {11'h0, ch_r[1], ch_r[0], (ev_prog != 2'h0), al1_vis, run_vis, prog_vis,
                   lk2_vis, lk1_vis, ct2_vis, ct1_vis, ramp_vis, am_offered, act_idx_r,
                   prog_run_r, run_r, manual_r};

  // Lamp and flashing follow the alarms of each channel
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      lamp_r <= 1'b0;
      flash_r <= 4'h0;
      stop_lamp_r <= 1'b0;
    end else begin
      lamp_r <= |{ch_r[0], ch_r[1]};
      flash_r <= {ch_r[1].hs, ch_r[0].hs, ch_r[1].hb | ch_r[1].oc, ch_r[0].hb | ch_r[0].oc}
                 & {4{blink_r}};
      stop_lamp_r <= ~run_r;
    end
  end

  // Read data stands in the cycle after the strobe only; unmapped reads give zero
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n)
      rdata_r <= 32'h0;
    else if (!RD_I)
      rdata_r <= 32'h0;
    else begin
      unique case (ADDR_I)
        `COLM_A_CFG: rdata_r <= 32'(cfg_r);
        `COLM_A_SP: rdata_r <= {16'h0, sp_r};
        `COLM_A_AL1: rdata_r <= {16'h0, al1_r};
        `COLM_A_RUN: rdata_r <= {31'h0, run_r};
        `COLM_A_PROG: rdata_r <= {31'h0, prog_run_r};
        `COLM_A_STAT: rdata_r <= status;
        `COLM_A_CTMON: rdata_r <= {mon_r[1], mon_r[0]};
        `COLM_A_LKMON: rdata_r <= {mon_r[3], mon_r[2]};
        `COLM_A_RSMON: rdata_r <= {soak_rem_r, ramp_r};
        default: rdata_r <= 32'h0;
      endcase
    end
  end

  assign RDATA_O = rdata_r;
  assign MANUAL_O = manual_r;
  assign MANUAL_LEVEL_O = man_lvl_r;
  assign RUN_O = run_r;
  assign STOP_LAMP_O = stop_lamp_r;
  assign PROG_RUN_O = prog_run_r;
  assign HEATER_ALARM_LAMP_O = lamp_r;
  assign FLASH_O = flash_r;
  assign RAMP_SP_O = ramp_r;

  // ****************************************
  // Assertions
  // ****************************************
  key_manual_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    key_fire |=> manual_r && man_lvl_r) else $error("Held key did not enter manual");
  short_press_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    $fell(key_s2) && (ev_am == 2'h0) && !(WR_I && ADDR_I == `COLM_A_AUTO) |=> $stable(manual_r))
    else $error("Key release changed mode");
  key_count_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    key_fire |-> key_cnt == KEY_HOLD_CYC - 1) else $error("Manual entered at wrong count");
  ramp_off_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (ramp_rate_r == 16'h0000) ##1 (ramp_rate_r == 16'h0000) && $stable(target) |-> ramp_r == target)
    else $error("Ramp differs from target with no ramp");
  gate_hb_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    !on_long |=> $stable(ch_r[0].hb) && $stable(ch_r[0].oc)) else $error("Burnout judged in short period");
  gate_hs_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    !off_long |=> $stable(ch_r[0].hs)) else $error("Short judged in short off period");
  overflow_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (CT_HEAT1_I > `COLM_CUR_MAX) |=> mon_r[0] == `COLM_CUR_OVF) else $error("No overflow pattern");
  lamp_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (ch_r[0] != 3'h0) |=> lamp_r) else $error("Alarm lamp not lit");
  prog_run_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    prog_start && (ev_run == 2'h0) |=> run_r && prog_run_r) else $error("Program start did not run");
  prog_stop_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    prog_stop && !prog_start |=> !prog_run_r) else $error("Program did not stop");
  stop_lamp_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    !run_r ##1 !run_r |-> stop_lamp_r) else $error("Stop lamp dark while stopped");
  al1_range_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    $signed(al1_r) >= $signed(`COLM_AL_MIN) && $signed(al1_r) <= $signed(`COLM_AL_MAX))
    else $error("Alarm 1 value out of range");

endmodule : colm_top

// ### colm_partner.sv
// Far-side model: mode key, event inputs, heating output and current sensors
module colm_partner (
  input wire logic clk_i,
  output logic key_o,
  output logic [1:0] event_o,
  output logic heat_o,
  output logic [15:0] heat1_o,
  output logic [15:0] heat2_o,
  output logic [15:0] leak1_o,
  output logic [15:0] leak2_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet pins from time zero
  initial begin
    {key_o, event_o, heat_o} = 4'h0;
    {heat1_o, heat2_o, leak1_o, leak2_o} = 64'h0;
  end
  // Key held n cycles; every change lands just after an edge
  task automatic press(input int n);
    @(posedge clk_i);
    key_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    key_o <= 1'b0;
  endtask : press
  // One heating on-period of n cycles
  task automatic heat(input int n);
    @(posedge clk_i);
    heat_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    heat_o <= 1'b0;
  endtask : heat
  // Event levels
  task automatic set_ev(input logic [1:0] v);
    @(posedge clk_i);
    event_o <= v;
  endtask : set_ev
  // Each channel gets its own currents, so a mix-up of the channels shows
  task automatic set_ct(input logic [15:0] h1, input logic [15:0] l1, input logic [15:0] h2, input logic [15:0] l2);
    @(posedge clk_i);
    heat1_o <= h1;
    leak1_o <= l1;
    heat2_o <= h2;
    leak2_o <= l2;
  endtask : set_ct
endmodule : colm_partner

// ### colm_tb.sv
// Self-checking testbench of the operation-level monitor
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, we, re, shown;
  logic key, heat, manual, level, run, stop, prun, lamp;
  logic [1:0] ev;
  logic [3:0] flash;
  logic [7:0] addr;
  logic [15:0] h1, h2, l1, l2, ramp;
  logic [31:0] wdata, rdata, d;
  int err_count, tests_run, lvl_cnt;
  // Counts are shortened so the whole run stays brief
  colm_top #(.KEY_HOLD_CYC(30), .GATE_CYC(10), .SEC_CYC(20)) uut (.CLK_I(clk), .NRST_I(rst_n), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(we), .RD_I(re), .RDATA_O(rdata), .MODE_KEY_I(key), .EVENT_IN_I(ev),
    .AM_ITEM_SHOWN_I(shown), .HEAT_OUT_I(heat), .CT_HEAT1_I(h1), .CT_HEAT2_I(h2), .CT_LEAK1_I(l1),
    .CT_LEAK2_I(l2), .MANUAL_O(manual), .MANUAL_LEVEL_O(level), .RUN_O(run), .STOP_LAMP_O(stop),
    .PROG_RUN_O(prun), .HEATER_ALARM_LAMP_O(lamp), .FLASH_O(flash), .RAMP_SP_O(ramp));
  colm_partner pm (.clk_i(clk), .key_o(key), .event_o(ev), .heat_o(heat), .heat1_o(h1), .heat2_o(h2),
    .leak1_o(l1), .leak2_o(l2));
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Manual-level pulses, counted so a doubled pulse shows
  always @(posedge clk) if (level === 1'b1) lvl_cnt++;
  // ****************************************
  // Bus cycles and comparison
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk(32'({run, stop, prun, manual, lamp, flash}), 32'h100);
    rd(8'h3c);
    chk(d, 32'h0);
    rd(8'h30);
    chk(d, 32'h0);
    rd(8'h50);
    chk(d, 32'h0);
  endtask : t_reset
  task automatic t_run;
    wr(8'h2c, 32'h0);
    tick(1);
    chk(32'({run, stop}), 32'h1);
    wr(8'h2c, 32'h1);
    tick(1);
    chk(32'({run, stop}), 32'h2);
    wr(8'h00, 32'h1000);
    rd(8'h40);
    chk(32'(d[12]), 32'h0);
    pm.set_ev(2'h1);
    wr(8'h2c, 32'h1);
    tick(5);
    chk(32'(run), 32'h0);
    pm.set_ev(2'h0);
    tick(5);
    chk(32'(run), 32'h1);
  endtask : t_run
  task automatic t_prog;
    wr(8'h00, 32'h200);
    wr(8'h28, 32'h1);
    rd(8'h40);
    chk(32'(d[12:11]), 32'h3);
    wr(8'h2c, 32'h0);
    wr(8'h30, 32'h1);
    tick(2);
    chk(32'({prun, run}), 32'h3);
    rd(8'h4c);
    chk(32'(d[31:16]), 32'h1);
    tick(1300);
    chk(32'(prun), 32'h0);
    wr(8'h30, 32'h1);
    wr(8'h30, 32'h0);
    tick(1);
    chk(32'(prun), 32'h0);
    wr(8'h00, 32'h2200);
    rd(8'h40);
    chk(32'(d[14]), 32'h1);
    wr(8'h30, 32'h1);
    tick(2);
    chk(32'(prun), 32'h0);
    pm.set_ev(2'h1);
    tick(5);
    chk(32'(prun), 32'h1);
    pm.set_ev(2'h0);
  endtask : t_prog
  task automatic t_key;
    wr(8'h00, 32'h2);
    rd(8'h40);
    chk(32'(d[5]), 32'h0);
    wr(8'h00, 32'h3);
    rd(8'h40);
    chk(32'(d[5]), 32'h1);
    @(posedge clk) shown <= 1'b1;
    pm.press(20);
    tick(10);
    chk(32'(manual), 32'h0);
    pm.press(40);
    tick(5);
    chk(32'({manual, 8'(lvl_cnt)}), 32'h101);
    wr(8'h38, 32'h1);
    tick(1);
    chk(32'(manual), 32'h0);
    @(posedge clk) shown <= 1'b0;
    // An event input that owns auto/manual hides the item and sets the mode
    wr(8'h00, 32'h1803);
    rd(8'h40);
    chk(32'(d[5]), 32'h0);
    pm.set_ev(2'h1);
    tick(5);
    chk(32'(manual), 32'h1);
    pm.set_ev(2'h0);
    tick(5);
    chk(32'(manual), 32'h0);
  endtask : t_key
  // Ramp rate off, so the ramp output follows the chosen preset
  task automatic t_msp;
    wr(8'h00, 32'h4);
    for (int i = 0; i < 4; i++) begin
      wr(8'h08 + 8'(4 * i), 32'(11 * (i + 1)));
    end
    wr(8'h34, 32'h2);
    tick(2);
    chk(32'(ramp), 32'h21);
    wr(8'h00, 32'h4804);
    for (int i = 0; i < 4; i++) begin
      pm.set_ev(2'(i));
      tick(5);
      chk(32'(ramp), 32'(11 * (i + 1)));
    end
    pm.set_ev(2'h0);
    rd(8'h40);
    chk(32'(d[6]), 32'h0);
    wr(8'h18, 32'h5);
    rd(8'h40);
    chk(32'(d[6]), 32'h1);
    wr(8'h00, 32'h104);
    rd(8'h40);
    chk(32'(d[6]), 32'h0);
    // Target is now preset 2 (33) and the ramp climbs from 11 by 5 each second
    for (int i = 0; i < 40 && ramp === 16'h000b; i++) tick(1);
    chk(32'(ramp), 32'h10);
    tick(20);
    chk(32'(ramp), 32'h15);
  endtask : t_msp
  task automatic t_cur;
    wr(8'h00, 32'h18);
    rd(8'h40);
    chk(32'(d[10:7]), 32'h1);
    pm.set_ct(16'h0227, 16'h0000, 16'h0226, 16'h0227);
    rd(8'h44);
    chk(d, 32'h0226ffff);
    rd(8'h48);
    chk(d, 32'hffff0000);
    pm.set_ct(16'h0226, 16'h0000, 16'h0226, 16'h0000);
    rd(8'h44);
    chk(d, 32'h02260226);
    wr(8'h1c, 32'h64);
    pm.set_ct(16'h0032, 16'h0000, 16'h0080, 16'h0000);
    pm.heat(8);
    tick(3);
    chk(32'(lamp), 32'h0);
    pm.heat(30);
    tick(2);
    chk(32'(lamp), 32'h1);
    wr(8'h24, 32'h0a);
    wr(8'h00, 32'h58);
    pm.set_ct(16'h0032, 16'h0032, 16'h0080, 16'h0000);
    // The short alarm is judged only once the off-period is long enough
    tick(8);
    rd(8'h40);
    chk(32'(d[15]), 32'h1);
    for (int i = 0; i < 60 && flash[0] !== 1'b1; i++) tick(1);
    chk(32'({flash[2], flash[0]}), 32'h3);
    // Second transformer on: channel 2 burnout and overcurrent, no short
    wr(8'h20, 32'h40);
    wr(8'h00, 32'hf8);
    rd(8'h40);
    chk(32'(d[10:7]), 32'hf);
    pm.set_ct(16'h0032, 16'h0032, 16'h0050, 16'h0000);
    pm.heat(30);
    rd(8'h40);
    chk(32'(d[20:15]), 32'h35);
    for (int i = 0; i < 60 && flash[1] !== 1'b1; i++) tick(1);
    chk(32'({flash[3], flash[1]}), 32'h1);
  endtask : t_cur
  task automatic t_alarm;
    wr(8'h00, 32'h20008);
    rd(8'h40);
    chk(32'(d[13]), 32'h0);
    wr(8'h3c, 32'h5);
    rd(8'h3c);
    chk(d, 32'h0);
    wr(8'h00, 32'h40008);
    wr(8'h3c, 32'h64);
    rd(8'h3c);
    chk(d, 32'h64);
    wr(8'h3c, 32'h2ee0);
    rd(8'h3c);
    chk(d, 32'h270f);
    wr(8'h3c, 32'hfffff63c);
    rd(8'h3c);
    chk(d, 32'hf831);
  endtask : t_alarm
  // Reset again mid-run, with alarms and a clamped value standing
  task automatic t_rst2;
    @(posedge clk) rst_n <= 1'b0;
    tick(2);
    chk(32'({run, stop, prun, manual, lamp, flash}), 32'h100);
    chk(32'(ramp), 32'h0);
    @(posedge clk) rst_n <= 1'b1;
    tick(4);
    rd(8'h3c);
    chk(d, 32'h0);
  endtask : t_rst2
  task automatic close_out;
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  // Main sequence: reset for five cycles, then every scenario
  initial begin
    rst_n <= 1'b0;
    we <= 1'b0;
    re <= 1'b0;
    shown <= 1'b0;
    addr <= 8'h00;
    wdata <= 32'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    tick(4);
    t_reset();
    t_run();
    t_key();
    t_msp();
    t_prog();
    t_cur();
    t_alarm();
    t_rst2();
    close_out();
  end
  // Watchdog: the run needs about 1800 cycles, so 12500 means a hang
  initial begin
    #100us;
    err_count++;
    close_out();
  end
endmodule : tb
